/* File: design/burst_blank_map.vh */
/*
 * Constants for the burst and blanking control block: time base, documented
 * delays, counter terminal values and burst level selection codes.
 * Assumes it is included by bare name from the design file that uses it.
 */
`ifndef BURST_BLANK_MAP_VH
`define BURST_BLANK_MAP_VH

// Internal time base in kHz (100 MHz).
`define CLK_FREQ_KHZ 100000
// Fixed overload and burst blanking interval in ms.
`define BLANK_TIME_MS 20
// Spike blanking before auto-restart, in ms.
`define SPIKE_TIME_MS 30
// Burst level detection window in ms.
`define DETECT_TIME_MS 1
// Cycle counts of the three times at 100 MHz (2,000,000, 3,000,000 and
// 100,000), written at the counter width so no wider product meets them.
`define BLANK_CYCLES 22'h1E_8480
`define SPIKE_CYCLES 22'h2D_C6C0
`define DETECT_CYCLES 22'h01_86A0
// Width of the time counters; holds 3,000,000.
`define TIME_CNT_W 22
// Terminal value of the extended cycle counter (256).
`define EXT_CYCLES 9'h100
// Default upper count limits of the three burst entry selections.
`define DET_LIMIT_HI 16'h0004
`define DET_LIMIT_MID 16'h0010
`define DET_LIMIT_LO 16'h0040
// Burst level selection codes.
`define SEL_160MV 2'h0
`define SEL_142MV 2'h1
`define SEL_127MV 2'h2
`define SEL_NEVER 2'h3
// Number of synchronised comparator and pin inputs.
`define N_SYNC 12

`endif

/* File: design/burst_blanking_control.v */
/*
 * Burst and blanking control: overload blanking with extendable cycle
 * counter, one-time burst entry level detection and the burst state machine.
 * Assumes analog comparators and switches outside, all asynchronous to
 * clk_sys_i, and a 100 MHz internal time base.
 */
//
// Summary of operation
// [RL1] Fixed 20 ms blanking before overload action.
// [RL2] Extended mode blocks gate until counter done.
// [RL3] Blanking expiry starts counter, closes charge switch.
// [RL4] Upper level: count, charge off, discharge on.
// [RL5] Lower level: discharge off, charge on.
// [RL6] At count 256 drive counter output high.
// [RL7] Gate high: spike delay then auto-restart.
// [RL8] Four selections; the fourth never enters burst.
// [RL9] Count picks entry threshold and burst limit.
// [RL10] Detect only in first window, first start.
// [RL11] Hold detection while a protection is active; code only delays the start, not a running window.
// [RL12] Upper level: set flip-flop, discharge, count.
// [RL13] Lower level: reset flip-flop, open discharge.
// [RL14] Burst blanking counts below threshold, then enters.
// [RL15] Burst entry sets flag, switches bias off.
// [RL16] Wake level turns bias back on.
// [RL17] Burst mode selects the burst current limit.
// [RL18] Sleep level switches bias off again.
// [RL19] Exit level leaves burst, clears flag.
// [RL20] Overload level starts the overload blanking counter.
// [RL21] All comparator inputs pass two flip-flops.
// [RL22] Undervoltage lockout clears counters and flags, except the detection results.
`timescale 1ns/10ps
`default_nettype none
`include "burst_blank_map.vh"

module burst_blanking_control
#(
   parameter [`TIME_CNT_W-1:0] BLANK_CYCLES = `BLANK_CYCLES,
   parameter [`TIME_CNT_W-1:0] SPIKE_CYCLES = `SPIKE_CYCLES,
   parameter [`TIME_CNT_W-1:0] DETECT_CYCLES = `DETECT_CYCLES,
   parameter [8:0] EXT_CYCLES = `EXT_CYCLES,
   parameter [15:0] DET_LIMIT_HI = `DET_LIMIT_HI,
   parameter [15:0] DET_LIMIT_MID = `DET_LIMIT_MID,
   parameter [15:0] DET_LIMIT_LO = `DET_LIMIT_LO
)
(
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire uvlo_on_i,
   input wire protect_active_i,
   input wire ext_blank_mode_i,
   input wire overload_cmp_i,
   input wire blank_upper_cmp_i,
   input wire blank_lower_cmp_i,
   input wire detect_upper_cmp_i,
   input wire detect_lower_cmp_i,
   input wire burst_entry_cmp_i,
   input wire burst_wake_cmp_i,
   input wire burst_sleep_cmp_i,
   input wire burst_exit_cmp_i,
   output reg blank_charge_sw_o,
   output reg blank_discharge_sw_o,
   output reg ext_count_done_o,
   output reg auto_restart_o,
   output reg detect_discharge_sw_o,
   output reg detect_done_o,
   output reg [1:0] burst_sel_o,
   output reg burst_flag_o,
   output reg burst_limit_en_o,
   output reg bias_on_o
);

   localparam [1:0] ST_NORMAL = 2'h0;
   localparam [1:0] ST_ENTRY = 2'h1;
   localparam [1:0] ST_SLEEP = 2'h2;
   localparam [1:0] ST_AWAKE = 2'h3;

   reg [`N_SYNC-1:0] meta_r;
   reg [`N_SYNC-1:0] sync_r;
   wire uvlo_s;
   wire prot_s;
   wire ext_mode_s;
   wire ovl_s;
   wire bup_s;
   wire blo_s;
   wire dup_s;
   wire dlo_s;
   wire entry_s;
   wire wake_s;
   wire sleep_s;
   wire exit_s;
   wire clr;
   reg [`TIME_CNT_W-1:0] ovl_cnt_r;
   reg blank_done_r;
   reg [8:0] ext_cnt_r;
   reg [`TIME_CNT_W-1:0] spike_cnt_r;
   wire gate_high;
   reg det_run_r;
   reg [`TIME_CNT_W-1:0] det_cnt_r;
   reg [15:0] det_pulses_r;
   reg [1:0] state_r;
   reg [`TIME_CNT_W-1:0] burst_cnt_r;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchroniser. Every pin arrives asynchronously, so nothing reads
   // the first stage except the second one.
   always @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         meta_r <= {`N_SYNC{1'b0}};
         sync_r <= {`N_SYNC{1'b0}};
      end
      else
      begin
         meta_r <= {burst_exit_cmp_i, burst_sleep_cmp_i, burst_wake_cmp_i,
                    burst_entry_cmp_i, detect_lower_cmp_i, detect_upper_cmp_i,
                    blank_lower_cmp_i, blank_upper_cmp_i, overload_cmp_i,
                    ext_blank_mode_i, protect_active_i, uvlo_on_i}; // see [RL21]
         sync_r <= meta_r;
      end
   end

   assign uvlo_s = sync_r[0];
   assign prot_s = sync_r[1];
   assign ext_mode_s = sync_r[2];
   assign ovl_s = sync_r[3];
   assign bup_s = sync_r[4];
   assign blo_s = sync_r[5];
   assign dup_s = sync_r[6];
   assign dlo_s = sync_r[7];
   assign entry_s = sync_r[8];
   assign wake_s = sync_r[9];
   assign sleep_s = sync_r[10];
   assign exit_s = sync_r[11];

   // Lockout clears the working state; detection results survive it.
   assign clr = sys_rst_i | ~uvlo_s; // see [RL22]

   ////////////////////////////////////////////////////////////////////////////
   // Overload blanking. The counter only runs while the overload level is
   // seen; a short peak that drops back restarts the whole interval.
   always @(posedge clk_sys_i)
   begin
      if (clr || !ovl_s)
      begin
         ovl_cnt_r <= {`TIME_CNT_W{1'b0}};
         blank_done_r <= 1'b0;
      end
      else if (ovl_cnt_r == BLANK_CYCLES - 1'b1)
      begin
         blank_done_r <= 1'b1; // see [RL1]
      end
      else
      begin
         ovl_cnt_r <= ovl_cnt_r + 1'b1; // see [RL20]
      end
   end

   // Extended cycle counter driving the charge and discharge switches.
   // Switches are never closed together, even for one cycle.
   always @(posedge clk_sys_i)
   begin
      if (clr || !ovl_s || !ext_mode_s)
      begin
         ext_cnt_r <= 9'h000;
         blank_charge_sw_o <= 1'b0;
         blank_discharge_sw_o <= 1'b0;
         ext_count_done_o <= 1'b0;
      end
      else if (blank_done_r && !ext_count_done_o)
      begin
         if (ext_cnt_r == EXT_CYCLES)
         begin
            ext_count_done_o <= 1'b1; // see [RL6]
            blank_charge_sw_o <= 1'b0;
            blank_discharge_sw_o <= 1'b0;
         end
         else if (blank_charge_sw_o && bup_s)
         begin
            ext_cnt_r <= ext_cnt_r + 1'b1; // see [RL4]
            blank_charge_sw_o <= 1'b0;
            blank_discharge_sw_o <= 1'b1;
         end
         else if (blank_discharge_sw_o && blo_s)
         begin
            blank_discharge_sw_o <= 1'b0; // see [RL5]
            blank_charge_sw_o <= 1'b1;
         end
         else if (!blank_charge_sw_o && !blank_discharge_sw_o)
         begin
            blank_charge_sw_o <= 1'b1; // see [RL3]
         end
      end
   end

   // Restart gate: in basic mode the second input is simply high.
   assign gate_high = blank_done_r && (!ext_mode_s || ext_count_done_o); // see [RL2]

   // Spike blanking, then auto-restart holds until lockout.
   always @(posedge clk_sys_i)
   begin
      if (clr)
      begin
         spike_cnt_r <= {`TIME_CNT_W{1'b0}};
         auto_restart_o <= 1'b0;
      end
      else if (!gate_high)
      begin
         spike_cnt_r <= {`TIME_CNT_W{1'b0}};
      end
      else if (spike_cnt_r == SPIKE_CYCLES - 1'b1)
      begin
         auto_restart_o <= 1'b1; // see [RL7]
      end
      else
      begin
         spike_cnt_r <= spike_cnt_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Burst level detection. The done flag and the selection are cleared only
   // by the system reset, so restarts after lockout never detect again.
   always @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         detect_done_o <= 1'b0;
         burst_sel_o <= `SEL_NEVER;
      end
      else if (det_run_r && det_cnt_r == DETECT_CYCLES - 1'b1)
      begin
         detect_done_o <= 1'b1; // see [RL10]
         if (det_pulses_r <= DET_LIMIT_HI)
            burst_sel_o <= `SEL_160MV; // see [RL9]
         else if (det_pulses_r <= DET_LIMIT_MID)
            burst_sel_o <= `SEL_142MV;
         else if (det_pulses_r <= DET_LIMIT_LO)
            burst_sel_o <= `SEL_127MV;
         else
            burst_sel_o <= `SEL_NEVER; // see [RL8]
      end
   end

   // Detection window with the charge and discharge flip-flop.
   always @(posedge clk_sys_i)
   begin
      if (clr || detect_done_o)
      begin
         det_run_r <= 1'b0;
         det_cnt_r <= {`TIME_CNT_W{1'b0}};
         det_pulses_r <= 16'h0000;
         detect_discharge_sw_o <= 1'b0;
      end
      else if (!det_run_r)
      begin
         det_run_r <= !prot_s; // see [RL11]
      end
      else if (det_cnt_r == DETECT_CYCLES - 1'b1)
      begin
         det_run_r <= 1'b0;
         detect_discharge_sw_o <= 1'b0;
      end
      else
      begin
         det_cnt_r <= det_cnt_r + 1'b1;
         if (!detect_discharge_sw_o && dup_s)
         begin
            detect_discharge_sw_o <= 1'b1; // see [RL12]
            det_pulses_r <= det_pulses_r + 1'b1;
         end
         else if (detect_discharge_sw_o && dlo_s)
         begin
            detect_discharge_sw_o <= 1'b0; // see [RL13]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Burst state machine. Exit has priority in every burst state because a
   // load jump must get the full current limit back at once.
   always @(posedge clk_sys_i)
   begin
      if (clr)
      begin
         state_r <= ST_NORMAL;
         burst_cnt_r <= {`TIME_CNT_W{1'b0}};
         burst_flag_o <= 1'b0;
         burst_limit_en_o <= 1'b0;
         bias_on_o <= 1'b1;
      end
      else
      begin
         case (state_r)
            ST_NORMAL:
            begin
               burst_cnt_r <= {`TIME_CNT_W{1'b0}}; // see [RL14]
               if (entry_s && detect_done_o && burst_sel_o != `SEL_NEVER)
                  state_r <= ST_ENTRY;
            end
            ST_ENTRY:
            begin
               if (!entry_s)
               begin
                  state_r <= ST_NORMAL;
               end
               else if (burst_cnt_r == BLANK_CYCLES - 1'b1)
               begin
                  state_r <= ST_SLEEP; // see [RL14]
                  burst_flag_o <= 1'b1; // see [RL15]
                  burst_limit_en_o <= 1'b1; // see [RL17]
                  bias_on_o <= 1'b0;
               end
               else
               begin
                  burst_cnt_r <= burst_cnt_r + 1'b1;
               end
            end
            ST_SLEEP:
            begin
               if (exit_s)
               begin
                  state_r <= ST_NORMAL; // see [RL19]
                  burst_flag_o <= 1'b0;
                  burst_limit_en_o <= 1'b0;
                  bias_on_o <= 1'b1;
               end
               else if (wake_s)
               begin
                  state_r <= ST_AWAKE;
                  bias_on_o <= 1'b1; // see [RL16]
               end
            end
            ST_AWAKE:
            begin
               if (exit_s)
               begin
                  state_r <= ST_NORMAL; // see [RL19]
                  burst_flag_o <= 1'b0;
                  burst_limit_en_o <= 1'b0;
               end
               else if (sleep_s)
               begin
                  state_r <= ST_SLEEP;
                  bias_on_o <= 1'b0; // see [RL18]
               end
            end
            default:
            begin
               state_r <= ST_NORMAL;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

/* File: test/bbc_pin_model.sv */
/* Analog pin model: blanking capacitor pin and feedback pin with their comparators.
   Assumes the switch outputs of the control block and one clock. */
`timescale 1ns/10ps
`default_nettype none
module bbc_pin_model
(
   input wire logic clk_i,
   input wire logic [7:0] k_i,
   input wire logic chg_i,
   input wire logic dis_i,
   input wire logic det_dis_i,
   output logic up_o,
   output logic lo_o,
   output logic dup_o,
   output logic dlo_o
);
   int v = 0;
   int d = 0;
   // Each pin moves one step a cycle between 0 and k_i, so a large k_i stands for a large capacitor.
   always @(posedge clk_i)
   begin
      v <= chg_i ? (v < k_i ? v + 1 : k_i) : (dis_i && v > 0 ? v - 1 : v);
      d <= !det_dis_i ? (d < k_i ? d + 1 : k_i) : (d > 0 ? d - 1 : 0);
   end
   // Comparators follow the levels at once; the block must do its own synchronising.
   assign up_o = v >= k_i;
   assign lo_o = v == 0;
   assign dup_o = d >= k_i;
   assign dlo_o = d == 0;
endmodule
`default_nettype wire

/* File: test/burst_blanking_control_asserts.sv */
/* Port checks of the burst and blanking control block.
   Assumes one clock domain and the synchronous reset sys_rst_i. */
`timescale 1ns/10ps
`default_nettype none
module burst_blanking_control_asserts
#(
   parameter int BLANK_CYCLES = 32'h0000_0014,
   parameter int SPIKE_CYCLES = 32'h0000_001E
)
(
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic uvlo_on_i,
   input wire logic overload_cmp_i,
   input wire logic burst_entry_cmp_i,
   input wire logic burst_wake_cmp_i,
   input wire logic burst_sleep_cmp_i,
   input wire logic burst_exit_cmp_i,
   input wire logic blank_charge_sw_o,
   input wire logic blank_discharge_sw_o,
   input wire logic ext_count_done_o,
   input wire logic auto_restart_o,
   input wire logic [1:0] burst_sel_o,
   input wire logic burst_flag_o,
   input wire logic burst_limit_en_o,
   input wire logic bias_on_o
);
   int ovl_run = 0;
   int ent_run = 0;
   // Run lengths of overload and entry levels; a mode may start only after its full delay.
   always @(posedge clk_sys_i)
   begin
      ovl_run <= (sys_rst_i || !overload_cmp_i) ? 0 : ovl_run + 1;
      ent_run <= (sys_rst_i || !burst_entry_cmp_i) ? 0 : ent_run + 1;
   end
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   // Four samples span both synchroniser stages and the output register.
   sequence s_ovl_low; !overload_cmp_i [*4]; endsequence
   sequence s_wake; (burst_flag_o && burst_wake_cmp_i && !burst_sleep_cmp_i && !burst_exit_cmp_i) [*4]; endsequence
   sequence s_sleep; (burst_flag_o && burst_sleep_cmp_i && !burst_wake_cmp_i && !burst_exit_cmp_i) [*4]; endsequence
   property p_ovl_clear; s_ovl_low |-> !blank_charge_sw_o && !blank_discharge_sw_o && !ext_count_done_o; endproperty
   a_ovl_clear: assert property (p_ovl_clear) else $error("blanking kept after overload drop");
   property p_uvlo_clear; !uvlo_on_i [*4] |-> !burst_flag_o && bias_on_o && !auto_restart_o; endproperty
   a_uvlo_clear: assert property (p_uvlo_clear) else $error("lockout did not clear");
   property p_restart; $rose(auto_restart_o) |-> ovl_run >= BLANK_CYCLES + SPIKE_CYCLES - 1; endproperty
   a_restart: assert property (p_restart) else $error("auto-restart too early");
   property p_entry; $rose(burst_flag_o) |-> ent_run >= BLANK_CYCLES && !bias_on_o && burst_sel_o != 2'h3; endproperty
   a_entry: assert property (p_entry) else $error("burst entry wrong");
   property p_limit; burst_limit_en_o == burst_flag_o; endproperty
   a_limit: assert property (p_limit) else $error("burst limit not tied to burst flag");
   property p_wake; s_wake |-> bias_on_o; endproperty
   a_wake: assert property (p_wake) else $error("bias off at wake level");
   property p_sleep; s_sleep |-> !bias_on_o; endproperty
   a_sleep: assert property (p_sleep) else $error("bias on at sleep level");
   property p_ext_done; $rose(ext_count_done_o) |-> !auto_restart_o; endproperty
   a_ext_done: assert property (p_ext_done) else $error("restart not held for spike delay");
endmodule
bind burst_blanking_control burst_blanking_control_asserts #(.BLANK_CYCLES(BLANK_CYCLES),
   .SPIKE_CYCLES(SPIKE_CYCLES)) chk_u (.*);
`default_nettype wire

/* File: test/burst_blanking_control_bench.sv */
/* Bench for the burst and blanking control block with the analog pin model.
   Assumes the design, the pin model and the checker are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
module burst_blanking_control_bench;
   localparam int B = 32'h0000_0014;
   localparam int S = 32'h0000_001E;
   logic clk_sys_i = 0, sys_rst_i = 1, uvlo_on_i = 1, protect_active_i = 1, ext_blank_mode_i = 0;
   logic overload_cmp_i = 0, burst_entry_cmp_i = 0, burst_wake_cmp_i = 0, burst_sleep_cmp_i = 0;
   logic burst_exit_cmp_i = 0, blank_upper_cmp_i, blank_lower_cmp_i, detect_upper_cmp_i, detect_lower_cmp_i;
   logic blank_charge_sw_o, blank_discharge_sw_o, ext_count_done_o, auto_restart_o, detect_discharge_sw_o;
   logic detect_done_o, burst_flag_o, burst_limit_en_o, bias_on_o;
   logic [1:0] burst_sel_o;
   logic [3:0] mon;
   logic [7:0] k = 8'h03;
   int fails = 0, checks_done = 0, n, i, dis_cnt, ddis_cnt;
   // Clock, watched outputs and counts of blanking and detection discharge cycles.
   always #5 clk_sys_i = ~clk_sys_i;
   assign mon = {detect_done_o, auto_restart_o, ext_count_done_o, burst_flag_o};
   always @(posedge blank_discharge_sw_o) dis_cnt++;
   always @(posedge detect_discharge_sw_o) ddis_cnt++;
   // Short times keep the run small; the detection count limits keep their real values.
   burst_blanking_control #(.BLANK_CYCLES(22'h00_0014), .SPIKE_CYCLES(22'h00_001E), .DETECT_CYCLES(22'h00_0258),
      .EXT_CYCLES(9'h004)) dut_u (.*);
   bbc_pin_model pin_u (.clk_i(clk_sys_i), .k_i(k), .chg_i(blank_charge_sw_o), .dis_i(blank_discharge_sw_o),
      .det_dis_i(detect_discharge_sw_o), .up_o(blank_upper_cmp_i), .lo_o(blank_lower_cmp_i),
      .dup_o(detect_upper_cmp_i), .dlo_o(detect_lower_cmp_i));
   ////////////////////////////////////////////////////////////////////////
   // Verdict, comparison and timing helpers; sampling is 1 ns after the edge so outputs have settled.
   task results;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic c, input string m);
      checks_done++;
      if (c !== 1'b1)
      begin
         fails++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task clk_up;
      @(posedge clk_sys_i);
   endtask
   task tick(input int c);
      repeat (c) @(posedge clk_sys_i);
      #1;
   endtask
   // Bounded wait for one watched output; n is left as the cycles waited.
   task wt(input int w, input int lim);
      for (n = 0; n < lim && mon[w] !== 1'b1; n++)
         tick(1);
      if (n == lim)
      begin
         chk(1'b0, "wait ran out");
         results();
      end
   endtask
   // Reset with a protection active, so detection waits until the scenario drops it.
   task rst_go(input logic [7:0] kk, input logic e);
      clk_up;
      sys_rst_i <= 1;
      k <= kk;
      ext_blank_mode_i <= e;
      protect_active_i <= 1;
      overload_cmp_i <= 0;
      burst_entry_cmp_i <= 0;
      dis_cnt = 0;
      ddis_cnt = 0;
      repeat (5) @(posedge clk_sys_i);
      sys_rst_i <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Burst level detection with a feedback pin of speed kk, then a restart that must not detect again.
   task t_detect(input logic [7:0] kk, input logic [1:0] esel);
      rst_go(kk, 1'b0);
      tick(3);
      chk(burst_sel_o === 2'h3 && bias_on_o === 1'b1 && burst_flag_o === 1'b0, "reset state");
      tick(120);
      chk(detect_done_o === 1'b0 && ddis_cnt == 0, "detection under protection");
      clk_up;
      protect_active_i <= 0;
      wt(3, 800);
      chk(burst_sel_o === esel, "burst level selection");
      chk(ddis_cnt > 0 && detect_discharge_sw_o === 1'b0, "detection cycles");
      clk_up;
      uvlo_on_i <= 0;
      k <= 8'h01;
      ddis_cnt = 0;
      tick(10);
      clk_up;
      uvlo_on_i <= 1;
      tick(650);
      chk(detect_done_o === 1'b1 && burst_sel_o === esel && ddis_cnt == 0, "detection on restart");
      clk_up;
      burst_entry_cmp_i <= 1;
      tick(60);
      chk(burst_flag_o === (esel != 2'h3), "burst entry per selection");
   endtask
   // Exit from the burst left by detection, entry dip, entry, wake, sleep, exit and lockout while in burst.
   task t_burst;
      clk_up;
      burst_entry_cmp_i <= 0;
      burst_exit_cmp_i <= 1;
      tick(4);
      chk(burst_flag_o === 1'b0 && bias_on_o === 1'b1, "burst exit from sleep");
      clk_up;
      burst_exit_cmp_i <= 0;
      burst_entry_cmp_i <= 1;
      tick(12);
      clk_up;
      burst_entry_cmp_i <= 0;
      tick(30);
      chk(burst_flag_o === 1'b0, "short dip entered burst");
      clk_up;
      burst_entry_cmp_i <= 1;
      wt(0, 100);
      chk(n >= B && bias_on_o === 1'b0 && burst_limit_en_o === 1'b1, "burst entry");
      clk_up;
      burst_wake_cmp_i <= 1;
      tick(3);
      chk(bias_on_o === 1'b1, "wake level");
      clk_up;
      burst_wake_cmp_i <= 0;
      burst_sleep_cmp_i <= 1;
      tick(3);
      chk(bias_on_o === 1'b0, "sleep level");
      clk_up;
      burst_sleep_cmp_i <= 0;
      burst_entry_cmp_i <= 0;
      burst_exit_cmp_i <= 1;
      tick(3);
      chk(!burst_flag_o && !burst_limit_en_o && bias_on_o, "burst exit");
      clk_up;
      burst_exit_cmp_i <= 0;
      burst_entry_cmp_i <= 1;
      wt(0, 100);
      clk_up;
      uvlo_on_i <= 0;
      tick(3);
      chk(burst_flag_o === 1'b0 && bias_on_o === 1'b1, "lockout in burst");
      clk_up;
      uvlo_on_i <= 1;
   endtask
   // Sustained overload; e selects the extendable mode with its capacitor cycles.
   task t_ovl(input logic e);
      rst_go(8'h03, e);
      clk_up;
      overload_cmp_i <= 1;
      if (e)
      begin
         wt(1, 2000);
         chk(dis_cnt == 4 && auto_restart_o === 1'b0, "extended count");
         wt(2, 200);
         chk(n >= S - 1, "spike delay");
         // A dropped overload clears the extended count but not the restart request.
         clk_up;
         overload_cmp_i <= 0;
         tick(4);
         chk(ext_count_done_o === 1'b0 && blank_discharge_sw_o === 1'b0, "overload drop");
         chk(auto_restart_o === 1'b1, "restart kept after drop");
      end
      else
      begin
         wt(2, 200);
         chk(n >= B + S - 1 && n <= B + S + 6 && !blank_charge_sw_o, "basic blanking");
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Pin speeds 100, 20, 5 and 1 give selections 0 to 3; the last detection leaves selection 0 for burst.
   initial
   begin
      for (i = 3; i >= 0; i--)
         t_detect(i == 0 ? 8'h64 : i == 1 ? 8'h14 : i == 2 ? 8'h05 : 8'h01, i[1:0]);
      t_burst();
      t_ovl(1'b0);
      t_ovl(1'b1);
      results();
   end
endmodule
`default_nettype wire
